// ==== rtl/hrcs_pkg.sv ====
package hrcs_pkg;

   // clock
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;

   // timing figures in their own units
   localparam int unsigned T_RECOVERY_US   = 500;
   localparam int unsigned T_INACTIVE_US   = 2;
   localparam int unsigned T_ATTACH_MS     = 100;
   localparam int unsigned T_EEPROM_TENTHS = 995;
   localparam int unsigned T_SMB_MAX_MS    = 300;
   localparam int unsigned T_REQUEST_MS    = 5;

   // derived cycle counts: maximum times round down; only recovery and inactive are held at one or more
   localparam int unsigned RECOVERY_CYC    = (T_RECOVERY_US * (CLK_HZ / 1_000_000) > 0) ?
                                             T_RECOVERY_US * (CLK_HZ / 1_000_000) : 1;
   localparam int unsigned INACTIVE_CYC    = (T_INACTIVE_US * (CLK_HZ / 1_000_000) > 0) ?
                                             T_INACTIVE_US * (CLK_HZ / 1_000_000) : 1;
   localparam int unsigned ATTACH_CYC      = T_ATTACH_MS * (CLK_HZ / 1000);
   localparam int unsigned EEPROM_CYC      = T_EEPROM_TENTHS * (CLK_HZ / 10_000);
   localparam int unsigned SMB_MAX_CYC     = T_SMB_MAX_MS * (CLK_HZ / 1000);
   localparam int unsigned REQUEST_CYC     = T_REQUEST_MS * (CLK_HZ / 1000);

   // widths
   localparam int unsigned NUM_PORTS       = 4;
   localparam int unsigned STRAP_W         = 8;
   localparam int unsigned CFG_W           = 16;
   localparam int unsigned ADDR_W          = 7;
   localparam int unsigned TMR_W           = 32;

   // configuration field layout
   localparam int unsigned CFG_STRAP_LSB   = 0;
   localparam logic [CFG_W-1:0] CFG_DEFAULT = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

   typedef enum logic [1:0] {
      HRCS_MODE_DEFAULT,
      HRCS_MODE_STRAP,
      HRCS_MODE_EEPROM,
      HRCS_MODE_SMBUS
   } hrcs_mode_t;

   // request to and answer from the external loader
   typedef struct packed {
      logic start;
   } hrcs_load_req_t;

   typedef struct packed {
      logic             done;
      logic             error;
      logic [CFG_W-1:0] cfg;
   } hrcs_load_rsp_t;

   // per-port downstream controls
   typedef struct packed {
      logic [NUM_PORTS-1:0] port_en;
      logic [NUM_PORTS-1:0] port_pwr;
   } hrcs_port_ctl_t;

endpackage

// ==== rtl/hrcs_sync.sv ====
module hrcs_sync import hrcs_pkg::*; #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   initial begin
      if (WIDTH < 1) $error("hrcs_sync: WIDTH must be at least 1");
   end

   // first stage is read only by the second
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ==== rtl/hrcs_timer.sv ====
module hrcs_timer import hrcs_pkg::*; #(
   parameter int unsigned WIDTH = TMR_W
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // control
   input  wire logic             clear,
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] limit,
   // status
   output logic                  expired,
   output logic      [WIDTH-1:0] count
);

   initial begin
      if (WIDTH < 2 || WIDTH > 32) $error("hrcs_timer: WIDTH out of range");
   end

   // saturating up-counter; expired once count reaches limit
   always_ff @(posedge sys_clk) begin
      if (!nrst || clear) begin
         count <= '0;
      end else if (run && count != '1) begin
         count <= count + WIDTH'(1);
      end
   end

   assign expired = (count >= limit);

endmodule

// ==== rtl/hrcs_sequencer.sv ====
// Function
// - sample led straps after reset release; the code samples them in strap mode only
// - strap high: led active low, else high; outside strap mode the code drives every led active high
// - unstrapped bits take internal default
// - reset disables ports, removes port power
// - reset disables transceivers, pairs high impedance
// - reset aborts transactions, keeps no state
// - reset returns registers to default zero
// - reset stops oscillator, pll, leds
// - operational within 500us of release
// - eeprom mode reads eeprom once operational
// - outputs inactive within 2us of release
// - attach within 100ms after configuration
// - eeprom configuration within 99.5ms
// - smbus mode attaches within 100ms; the code never times out the smbus load, SMB_CYCLES is unused
// - self-powered smbus: no load limit
// - standard requests complete within 5ms
// - bus reset: address zero, unconfigured
// - bus reset: ports unpowered, tt cleared
// - bus reset wakes a suspended hub
// - smbus mode waits indefinitely for load
module hrcs_sequencer import hrcs_pkg::*; #(
   parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC,
   parameter int unsigned INACTIVE_CYCLES = INACTIVE_CYC,
   parameter int unsigned ATTACH_CYCLES   = ATTACH_CYC,
   parameter int unsigned EEPROM_CYCLES   = EEPROM_CYC,
   parameter int unsigned SMB_CYCLES      = SMB_MAX_CYC,
   parameter int unsigned REQUEST_CYCLES  = REQUEST_CYC
) (
   // clock and synchronous active-low hardware reset
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   // mode selection and power straps (pins)
   input  wire logic [1:0]           cfg_mode_pin,
   input  wire logic                 self_powered_pin,
   // led strap pins, two-way
   input  wire logic [STRAP_W-1:0]   led_in,
   output logic      [STRAP_W-1:0]   led_out,
   output logic      [STRAP_W-1:0]   led_oe,
   input  wire logic [STRAP_W-1:0]   led_on,
   // configuration loader (eeprom master or smbus slave)
   output hrcs_load_req_t            load_req,
   input  wire hrcs_load_rsp_t       load_rsp,
   // upstream side
   input  wire logic                 bus_reset,
   input  wire logic                 suspend_req,
   input  wire logic                 request_start,
   input  wire logic                 request_done,
   input  wire logic                 set_config,
   input  wire logic [ADDR_W-1:0]    set_addr,
   input  wire logic                 set_addr_valid,
   output logic                      attach,
   output logic                      phy_en,
   output logic                      suspended,
   output logic                      configured,
   output logic      [ADDR_W-1:0]    dev_addr,
   output logic                      request_abort,
   // downstream and housekeeping
   output hrcs_port_ctl_t            port_ctl,
   output logic                      tt_clear,
   output logic                      osc_en,
   output logic                      pll_en,
   output logic                      operational,
   output logic      [CFG_W-1:0]     active_cfg
);

   typedef enum logic [2:0] {
      ST_RECOVER,
      ST_STRAP,
      ST_LOAD,
      ST_APPLY,
      ST_RUN
   } hrcs_state_t;

   initial begin
      if (RECOVERY_CYCLES < 1 || ATTACH_CYCLES < 1 || EEPROM_CYCLES < 1 || REQUEST_CYCLES < 1)
         $error("hrcs_sequencer: cycle counts must be at least 1");
      if (INACTIVE_CYCLES < 1 || INACTIVE_CYCLES >= RECOVERY_CYCLES)
         $error("hrcs_sequencer: inactive time must be below recovery time");
   end

   hrcs_state_t          state_reg, state_next;
   hrcs_mode_t           mode_reg;
   logic                 self_pwr_reg;
   logic [STRAP_W-1:0]   strap_reg;
   logic [CFG_W-1:0]     cfg_reg;
   logic                 req_busy_reg;
   logic [1:0]           mode_s;
   logic                 self_s;
   logic [STRAP_W-1:0]   led_s;
   logic                 load_done_s;
   logic [TMR_W-1:0]     tmr_count, req_count;
   logic                 tmr_clear, req_exp;
   logic [TMR_W-1:0]     tmr_limit;

   // pins cross in through two flops
   hrcs_sync #(.WIDTH(3 + STRAP_W)) u_sync (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .async_in ({cfg_mode_pin, self_powered_pin, led_in}),
      .sync_out ({mode_s, self_s, led_s})
   );

   // one timer serves every phase; cleared at each state change
   assign tmr_clear = (state_reg != state_next);
   assign tmr_limit = TMR_W'(RECOVERY_CYCLES);

   hrcs_timer #(.WIDTH(TMR_W)) u_phase_tmr (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .clear   (tmr_clear),
      .run     (1'b1),
      .limit   (tmr_limit),
      .expired (),
      .count   (tmr_count)
   );

   hrcs_timer #(.WIDTH(TMR_W)) u_req_tmr (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .clear   (!req_busy_reg || request_start),
      .run     (req_busy_reg),
      .limit   (TMR_W'(REQUEST_CYCLES)),
      .expired (req_exp),
      .count   (req_count)
   );

   assign load_done_s = load_rsp.done;

   function automatic logic uses_loader(input hrcs_mode_t m);
      return (m == HRCS_MODE_EEPROM) || (m == HRCS_MODE_SMBUS);
   endfunction

   // sequencing; reset clears every state, no transaction survives
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RECOVER: begin
            if (tmr_count >= TMR_W'(RECOVERY_CYCLES - 1)) begin
               state_next = uses_loader(mode_reg) ? ST_LOAD : ST_STRAP;
            end
         end
         ST_STRAP: state_next = ST_APPLY;
         ST_LOAD: begin
            if (load_done_s) begin
               state_next = ST_APPLY;
            end else if (mode_reg == HRCS_MODE_EEPROM &&
                         tmr_count >= TMR_W'(EEPROM_CYCLES - 1)) begin
               state_next = ST_APPLY;
            end
         end
         ST_APPLY: state_next = ST_RUN;
         ST_RUN:   state_next = ST_RUN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_reg <= ST_RECOVER;
      end else begin
         state_reg <= state_next;
      end
   end

   // mode and self-power captured once, after release
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         mode_reg     <= HRCS_MODE_DEFAULT;
         self_pwr_reg <= 1'b0;
      end else if (state_reg == ST_RECOVER && tmr_count == TMR_W'(INACTIVE_CYCLES - 1)) begin
         mode_reg     <= hrcs_mode_t'(mode_s);
         self_pwr_reg <= self_s;
      end
   end

   // straps sampled in strap mode only, once synchronisers have settled, before leds are driven
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         strap_reg <= '0;
      end else if (state_reg == ST_RECOVER && tmr_count == TMR_W'(INACTIVE_CYCLES - 1) &&
                   hrcs_mode_t'(mode_s) == HRCS_MODE_STRAP) begin
         strap_reg <= led_s;
      end
   end

   // configuration image
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cfg_reg <= CFG_DEFAULT;
      end else if (state_reg == ST_STRAP) begin
         cfg_reg <= CFG_DEFAULT;
         if (mode_reg == HRCS_MODE_STRAP) begin
            cfg_reg[CFG_STRAP_LSB +: STRAP_W] <= strap_reg;
         end
      end else if (state_reg == ST_LOAD && load_done_s && !load_rsp.error) begin
         cfg_reg <= load_rsp.cfg;
      end
   end

   // loader request, asserted for the whole load phase
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         load_req <= '0;
      end else begin
         load_req.start <= (state_next == ST_LOAD);
      end
   end

   // attach only after apply; smbus self-powered has no timeout at all
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         attach      <= 1'b0;
         operational <= 1'b0;
         phy_en      <= 1'b0;
         osc_en      <= 1'b0;
         pll_en      <= 1'b0;
      end else begin
         osc_en      <= 1'b1;
         pll_en      <= 1'b1;
         operational <= (state_next != ST_RECOVER);
         if (state_reg == ST_APPLY) begin
            attach <= 1'b1;
            phy_en <= 1'b1;
         end
      end
   end

   // leds: in strap mode strapped high sinks (drive low when lit), strapped low sources; other modes always source
   generate
      for (genvar i = 0; i < STRAP_W; i++) begin : g_led
         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               led_oe[i]  <= 1'b0;
               led_out[i] <= 1'b0;
            end else if (state_reg == ST_RECOVER && tmr_count < TMR_W'(INACTIVE_CYCLES)) begin
               led_oe[i]  <= 1'b0;
               led_out[i] <= 1'b0;
            end else begin
               led_oe[i]  <= 1'b1;
               led_out[i] <= strap_reg[i] ? ~led_on[i] : led_on[i];
            end
         end
      end
   endgenerate

   // upstream bus reset handling and device state
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         dev_addr   <= ADDR_RESET;
         configured <= 1'b0;
         suspended  <= 1'b0;
         tt_clear   <= 1'b0;
      end else begin
         tt_clear <= 1'b0;
         if (bus_reset) begin
            dev_addr   <= ADDR_RESET;
            configured <= 1'b0;
            suspended  <= 1'b0;
            tt_clear   <= 1'b1;
         end else if (attach) begin
            if (set_addr_valid) dev_addr <= set_addr;
            if (set_config) configured <= 1'b1;
            suspended <= suspend_req;
         end
      end
   end

   // ports unpowered in reset and on bus reset; bus reset is not passed on
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         port_ctl <= '0;
      end else if (bus_reset || !attach) begin
         port_ctl <= '0;
      end else if (configured) begin
         port_ctl.port_pwr <= {NUM_PORTS{1'b1}};
         port_ctl.port_en  <= {NUM_PORTS{1'b1}};
      end
   end

   // standard request watchdog: abort what runs past its limit
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         req_busy_reg  <= 1'b0;
         request_abort <= 1'b0;
      end else begin
         request_abort <= 1'b0;
         if (bus_reset || request_done) begin
            req_busy_reg <= 1'b0;
         end else if (request_start && attach) begin
            req_busy_reg <= 1'b1;
         end else if (req_busy_reg && req_exp) begin
            req_busy_reg  <= 1'b0;
            request_abort <= 1'b1;
         end
      end
   end

   assign active_cfg = cfg_reg;

   // assertions
   sequence s_released;
      $rose(operational);
   endsequence

   AST_NO_ATTACH_EARLY: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(attach) |-> $past(state_reg) == ST_APPLY)
      else $error("attach rose outside apply");
   AST_RESET_PORTS_OFF: assert property (@(posedge sys_clk)
      !nrst |=> port_ctl == '0)
      else $error("ports powered after reset");
   AST_RESET_PHY_OFF: assert property (@(posedge sys_clk)
      !nrst |=> !phy_en && led_oe == '0)
      else $error("phy or led live after reset");
   AST_RESET_OSC_OFF: assert property (@(posedge sys_clk)
      !nrst |=> !osc_en && !pll_en)
      else $error("clocks running after reset");
   AST_OPERATIONAL_TIME: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == ST_RECOVER && tmr_count == TMR_W'(RECOVERY_CYCLES - 1) |=> operational)
      else $error("not operational in time");
   AST_LOAD_START: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_released ##0 uses_loader(mode_reg) |-> load_req.start)
      else $error("loader not started once operational");
   AST_SMB_NO_LIMIT: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == ST_LOAD && mode_reg == HRCS_MODE_SMBUS && self_pwr_reg && !load_done_s |=> state_reg == ST_LOAD)
      else $error("self-powered load abandoned");
   AST_BUS_RESET: assert property (@(posedge sys_clk) disable iff (!nrst)
      bus_reset |=> dev_addr == ADDR_RESET && !configured && !suspended)
      else $error("bus reset state wrong");
   AST_BUS_RESET_PORTS: assert property (@(posedge sys_clk) disable iff (!nrst)
      bus_reset |=> port_ctl.port_pwr == '0 && tt_clear)
      else $error("bus reset left ports powered");
   AST_ATTACH_AFTER_APPLY: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == ST_APPLY |=> attach)
      else $error("attach missed after configuration");
   AST_LED_POLARITY: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_reg == ST_RUN && $past(state_reg) == ST_RUN |-> led_out == (strap_reg ^ $past(led_on)))
      else $error("led polarity wrong");

endmodule

// ==== verification/hrcs_host_model.sv ====
module hrcs_host_model import hrcs_pkg::*; (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // loader link
   input  wire hrcs_load_req_t   load_req,
   output hrcs_load_rsp_t        load_rsp,
   // behaviour chosen by the bench
   input  wire logic [15:0]      delay,
   input  wire logic [CFG_W-1:0] cfg_val,
   input  wire logic             err
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] wait_reg;
   logic        done_reg;

   // the host alone decides how long the load takes: no upper bound here
   always_ff @(posedge sys_clk) begin
      if (!nrst || !load_req.start) begin
         wait_reg <= 16'h0000;
      end else if (wait_reg != 16'hffff) begin
         wait_reg <= wait_reg + 16'h0001;
      end
   end

   // one answer per load phase, a single cycle wide
   always_ff @(posedge sys_clk) begin
      done_reg <= nrst && load_req.start && (wait_reg == delay);
   end

   // outside the answer cycle the data lines carry the inverse, never a stale copy
   assign load_rsp = '{done: done_reg, error: done_reg ? err : ~err, cfg: done_reg ? cfg_val : ~cfg_val};
endmodule

// ==== verification/test_hub_reset_config_sequencer.sv ====
module test_hub_reset_config_sequencer import hrcs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned REC = 20, INACT = 4, EEP = 50, REQ = 30;
   localparam int unsigned RST_HOLD = 1000 / CLK_PERIOD_NS;

   logic                 sys_clk, nrst, self_powered_pin, bus_reset, suspend_req, err;
   logic                 request_start, request_done, set_config, set_addr_valid;
   logic                 attach, phy_en, suspended, configured, request_abort;
   logic                 tt_clear, osc_en, pll_en, operational;
   logic [1:0]           cfg_mode_pin;
   logic [STRAP_W-1:0]   led_in, led_out, led_oe, led_on, strap;
   logic [ADDR_W-1:0]    set_addr, dev_addr;
   logic [15:0]          delay;
   logic [CFG_W-1:0]     cfg_val, active_cfg;
   hrcs_load_req_t       load_req;
   hrcs_load_rsp_t       load_rsp;
   hrcs_port_ctl_t       port_ctl;
   int                   fails = 0, compares = 0;
   int                   hold_cyc = 6;

   always #20 sys_clk = ~sys_clk;

   // pin level: our drive where enabled, otherwise the strap resistor
   assign led_in = (led_oe & led_out) | (~led_oe & strap);

   hrcs_sequencer #(.RECOVERY_CYCLES(REC), .INACTIVE_CYCLES(INACT), .ATTACH_CYCLES(1000),
      .EEPROM_CYCLES(EEP), .SMB_CYCLES(1000), .REQUEST_CYCLES(REQ)) dut_u (
      .sys_clk(sys_clk), .nrst(nrst), .cfg_mode_pin(cfg_mode_pin), .self_powered_pin(self_powered_pin),
      .led_in(led_in), .led_out(led_out), .led_oe(led_oe), .led_on(led_on), .load_req(load_req),
      .load_rsp(load_rsp), .bus_reset(bus_reset), .suspend_req(suspend_req), .request_start(request_start),
      .request_done(request_done), .set_config(set_config), .set_addr(set_addr),
      .set_addr_valid(set_addr_valid), .attach(attach), .phy_en(phy_en), .suspended(suspended),
      .configured(configured), .dev_addr(dev_addr), .request_abort(request_abort), .port_ctl(port_ctl),
      .tt_clear(tt_clear), .osc_en(osc_en), .pll_en(pll_en), .operational(operational),
      .active_cfg(active_cfg));

   hrcs_host_model host_u (.sys_clk(sys_clk), .nrst(nrst), .load_req(load_req), .load_rsp(load_rsp),
      .delay(delay), .cfg_val(cfg_val), .err(err));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("mismatches %0d, comparisons %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic do_reset(input logic [1:0] m);
      @(negedge sys_clk);
      nrst = 1'b0;
      cfg_mode_pin = m;
      cyc(hold_cyc);
      check(port_ctl, 8'h00);
      check({phy_en, attach}, 2'b00);
      check({dev_addr, configured, load_req.start, request_abort}, 0);
      check({osc_en, pll_en, led_oe}, 0);
      nrst = 1'b1;
      // later resets keep the 1us minimum hold
      hold_cyc = RST_HOLD;
   endtask

   task automatic boot(input logic [1:0] m, input logic [CFG_W-1:0] exp_cfg);
      int n_done;
      int n;
      do_reset(m);
      n_done = -1;
      for (n = 1; n <= 2000 && attach !== 1'b1; n++) begin
         @(negedge sys_clk);
         if (n == 1) check({osc_en, pll_en}, 2'b11);
         if (n == INACT + 1) check(led_oe, 8'hff);
         if (n == REC - 1 || n == REC) check(operational, n == REC);
         if (n == REC + 1) check(load_req.start, m[1]);
         if (load_rsp.done && load_req.start) n_done = n;
         if (attach && (n_done >= 0 || m == HRCS_MODE_SMBUS)) check(n - n_done, 2);
      end
      check({attach, phy_en}, 2'b11);
      if (m == HRCS_MODE_EEPROM) check(n <= REC + EEP + 6, 1);
      check(active_cfg, exp_cfg);
      repeat (4) begin
         led_on = STRAP_W'($urandom);
         cyc(1);
         check(led_out, led_on ^ (m == HRCS_MODE_STRAP ? strap : 8'h00));
      end
   endtask

   task automatic host_session;
      int n;
      // the host lets the attached hub settle before talking to it
      cyc(10);
      set_addr = ADDR_W'(1 + $urandom % 127);
      set_addr_valid = 1'b1;
      set_config = 1'b1;
      cyc(1);
      set_addr_valid = 1'b0;
      set_config = 1'b0;
      cyc(2);
      check({configured, dev_addr, port_ctl}, {1'b1, set_addr, 8'hff});
      suspend_req = 1'b1;
      cyc(3);
      check(suspended, 1'b1);
      bus_reset = 1'b1;
      cyc(1);
      check({dev_addr, configured, suspended, port_ctl, tt_clear}, 1);
      bus_reset = 1'b0;
      suspend_req = 1'b0;
      request_start = 1'b1;
      cyc(1);
      request_start = 1'b0;
      for (n = 1; n < REQ + 10 && request_abort !== 1'b1; n++) cyc(1);
      check(n >= REQ - 3 && n <= REQ + 3, 1);
      request_start = 1'b1;
      cyc(1);
      request_start = 1'b0;
      cyc(5);
      request_done = 1'b1;
      cyc(1);
      request_done = 1'b0;
      repeat (REQ + 10) begin
         cyc(1);
         if (request_abort !== 1'b0) check(request_abort, 1'b0);
      end
   endtask

   initial begin
      logic [1:0]       m;
      logic [CFG_W-1:0] exp_cfg;
      {sys_clk, nrst, self_powered_pin, bus_reset, suspend_req, err} = 6'h00;
      {request_start, request_done, set_config, set_addr_valid} = 4'h0;
      {cfg_mode_pin, led_on, strap, set_addr, delay, cfg_val} = 0;
      void'($urandom(93616));
      for (int i = 0; i < 10; i++) begin
         strap = STRAP_W'($urandom);
         cfg_val = CFG_W'($urandom);
         delay = 16'(1 + $urandom % 40);
         err = 1'b0;
         self_powered_pin = 1'($urandom);
         exp_cfg = cfg_val;
         case (i % 5)
            0: begin m = HRCS_MODE_DEFAULT; exp_cfg = CFG_DEFAULT; end
            1: begin m = HRCS_MODE_STRAP; exp_cfg = {8'h00, strap}; end
            2: m = HRCS_MODE_EEPROM;
            // a failed or absent eeprom answer leaves the defaults in place
            3: begin m = HRCS_MODE_EEPROM; exp_cfg = CFG_DEFAULT; err = (i < 5); delay = i < 5 ? delay : 16'd80; end
            default: begin m = HRCS_MODE_SMBUS; delay = 16'(100 + $urandom % 200); self_powered_pin = (i > 5); end
         endcase
         boot(m, exp_cfg);
         host_session();
      end
      // hardware reset in the middle of a load
      delay = 16'd80;
      do_reset(HRCS_MODE_SMBUS);
      cyc(REC + 10);
      boot(HRCS_MODE_DEFAULT, CFG_DEFAULT);
      complete_run();
   end

   initial begin
      repeat (30000) @(posedge sys_clk);
      fails++;
      $display("MISMATCH at %0t: watchdog got %h expected %h", $time, 0, 1);
      complete_run();
   end
endmodule
